// file: logic/pcd_dma.v
`timescale 1ns/1ns
`include "pcd_defs.vh"

module pcd_dma #(
  parameter DATA_W = 16,
  parameter ADDR_W = 16,
  parameter AXI_AW = 8
) (
  input  wire              sys_clk,
  input  wire              rst_b,
  input  wire [AXI_AW-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [AXI_AW-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              fifo_empty,
  input  wire              isa_irq9_in,
  input  wire              isa_ior_b,
  input  wire              isa_iow_b,
  input  wire              isa_tc_in,
  input  wire              isa_dma16,
  input  wire [DATA_W-1:0] isa_d_in,
  output reg  [DATA_W-1:0] isa_d_out_reg,
  output wire              isa_d_oe,
  output wire              isa_rdy,
  output wire              isa_irq10_out,
  output wire              isa_irq10_oe,
  input  wire              card_inpack_b,
  input  wire              card_iois16_b,
  input  wire              card_spkr_b,
  output wire              spkr_out,
  input  wire [DATA_W-1:0] card_d_in,
  output wire [DATA_W-1:0] card_d_out,
  output wire              card_d_oe,
  output wire [ADDR_W-1:0] card_addr,
  output wire [1:0]        card_ce_b,
  output wire              card_we_b,
  output wire              card_oe_b,
  output wire              card_iord_b,
  output wire              card_iowr_b,
  output wire              card_reg_b
);

  localparam integer SYNC_W = DATA_W + 8;

  // Picks the active-low request pin named by the select field
  function req_pick;
    input [1:0] sel;
    input       inpack_b;
    input       iois16_b;
    input       spkr_b;
    begin
      case (sel)
        `PCD_SEL_INPACK: req_pick = ~inpack_b;
        `PCD_SEL_IOIS16: req_pick = ~iois16_b;
        `PCD_SEL_SPKR:   req_pick = ~spkr_b;
        default:         req_pick = 1'b0;
      endcase
    end
  endfunction

  // Pin synchroniser: first stage read only by the second
  wire [SYNC_W-1:0] pin_raw;
  reg  [SYNC_W-1:0] pin_s1_reg;
  reg  [SYNC_W-1:0] pin_s2_reg;

  assign pin_raw = {isa_d_in, isa_dma16, isa_tc_in, isa_iow_b, isa_ior_b,
                    isa_irq9_in, card_spkr_b, card_iois16_b, card_inpack_b};

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg <= {SYNC_W{1'b1}};
      pin_s2_reg <= {SYNC_W{1'b1}};
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire              inpack_b_s = pin_s2_reg[0];
  wire              iois16_b_s = pin_s2_reg[1];
  wire              spkr_b_s   = pin_s2_reg[2];
  wire              dack_b_s   = pin_s2_reg[3];
  wire              ior_b_s    = pin_s2_reg[4];
  wire              iow_b_s    = pin_s2_reg[5];
  wire              tc_s       = pin_s2_reg[6];
  wire              dma16_s    = pin_s2_reg[7];
  wire [DATA_W-1:0] isa_d_s    = pin_s2_reg[SYNC_W-1:8];

  // Registers
  reg  [1:0]        sel_reg;
  reg               hs_en_reg;
  reg               dma_en_reg;
  reg  [1:0]        cmd_kind_reg;
  reg               cmd_wr_reg;
  reg               cmd_wide_reg;
  reg  [ADDR_W-1:0] cmd_addr_reg;
  reg  [DATA_W-1:0] cmd_data_reg;
  reg  [DATA_W-1:0] rd_data_reg;
  reg               ord_pend_reg;

  // DMA transfer state
  reg               ior_prev_reg;
  reg               iow_prev_reg;
  reg               dma_pend_reg;
  reg               dma_wr_reg;
  reg               dma_tc_reg;
  reg               dma_wide_reg;
  reg  [DATA_W-1:0] dma_data_reg;
  reg               start_reg;
  reg               own_dma_reg;
  reg               dma_run_reg;

  wire              gen_busy;
  wire              gen_done;
  wire [DATA_W-1:0] gen_rdata;

  wire dma_mode = dma_en_reg & hs_en_reg;
  wire dma_ok   = dma_mode & (sel_reg != `PCD_SEL_NONE);
  wire dack_on  = dma_ok & ~dack_b_s;
  wire req_on   = req_pick(sel_reg, inpack_b_s, iois16_b_s, spkr_b_s);
  wire ior_fall = ior_prev_reg & ~ior_b_s;
  wire iow_fall = iow_prev_reg & ~iow_b_s;

  // Request leaves only while socket FIFO is drained
  assign isa_irq10_out = dma_ok & req_on & fifo_empty;
  assign isa_irq10_oe  = dma_mode;
  // Speaker path is lost when that pin carries the request
  assign spkr_out      = (sel_reg == `PCD_SEL_SPKR) ? 1'b0 : ~spkr_b_s;
  // Holds the system strobe until the card side has finished
  assign isa_rdy       = ~(dma_pend_reg | dma_run_reg);
  assign isa_d_oe      = dack_on & ~ior_b_s & ~dma_run_reg & ~dma_pend_reg;

  // Capture system DMA strobes while acknowledged
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ior_prev_reg  <= 1'b1;
      iow_prev_reg  <= 1'b1;
      dma_pend_reg  <= 1'b0;
      dma_wr_reg    <= 1'b0;
      dma_tc_reg    <= 1'b0;
      dma_wide_reg  <= 1'b0;
      dma_data_reg  <= {DATA_W{1'b0}};
      isa_d_out_reg <= {DATA_W{1'b0}};
    end else begin
      ior_prev_reg <= ior_b_s;
      iow_prev_reg <= iow_b_s;
      if (dack_on && !dma_pend_reg && !dma_run_reg && (ior_fall || iow_fall)) begin
        dma_pend_reg <= 1'b1;
        dma_wr_reg   <= iow_fall;
        dma_tc_reg   <= dma_en_reg & tc_s;
        dma_wide_reg <= dma16_s;
        dma_data_reg <= isa_d_s;
      end else if (start_reg && own_dma_reg) begin
        dma_pend_reg <= 1'b0;
      end
      if (gen_done && own_dma_reg && !dma_wr_reg) begin
        isa_d_out_reg <= gen_rdata;
      end
    end
  end

  // Card cycle arbiter: DMA first, ordinary accesses fill the gaps
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_reg   <= 1'b0;
      own_dma_reg <= 1'b0;
      dma_run_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (gen_done) begin
        dma_run_reg <= 1'b0;
      end
      if (!gen_busy && !start_reg) begin
        if (dma_pend_reg) begin
          start_reg   <= 1'b1;
          own_dma_reg <= 1'b1;
          dma_run_reg <= 1'b1;
        end else if (ord_pend_reg) begin
          start_reg   <= 1'b1;
          own_dma_reg <= 1'b0;
        end
      end
    end
  end

  wire [1:0]        gen_kind  = own_dma_reg ? `PCD_KIND_DMA :
                                (dma_ok || cmd_kind_reg != `PCD_KIND_DMA) ? cmd_kind_reg :
                                `PCD_KIND_IO;
  wire              gen_wr    = own_dma_reg ? dma_wr_reg : cmd_wr_reg;
  wire              gen_tc    = own_dma_reg & dma_tc_reg;
  wire              gen_wide  = own_dma_reg ? dma_wide_reg : cmd_wide_reg;
  wire [DATA_W-1:0] gen_wdata = own_dma_reg ? dma_data_reg : cmd_data_reg;

  pcd_cycle_gen #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_cycle (
    .sys_clk         (sys_clk),
    .rst_b           (rst_b),
    .start           (start_reg),
    .kind            (gen_kind),
    .wr              (gen_wr),
    .tc              (gen_tc),
    .wide            (gen_wide),
    .addr            (cmd_addr_reg),
    .wdata           (gen_wdata),
    .card_d_in       (card_d_in),
    .busy            (gen_busy),
    .done_reg        (gen_done),
    .rdata_reg       (gen_rdata),
    .card_we_b_reg   (card_we_b),
    .card_oe_b_reg   (card_oe_b),
    .card_iord_b_reg (card_iord_b),
    .card_iowr_b_reg (card_iowr_b),
    .card_reg_b_reg  (card_reg_b),
    .card_ce_b_reg   (card_ce_b),
    .card_addr_reg   (card_addr),
    .card_d_out_reg  (card_d_out),
    .card_d_oe_reg   (card_d_oe)
  );

  // AXI4-Lite write: address and data taken together
  wire              wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire [AXI_AW-1:0] wa      = s_axi_awaddr;
  wire              wa_map  = (wa == `PCD_OFF_EXT_CTRL1) || (wa == `PCD_OFF_MISC_CTRL2) ||
                              (wa == `PCD_OFF_STATUS) || (wa == `PCD_OFF_CARD_CMD) ||
                              (wa == `PCD_OFF_CARD_ADDR) || (wa == `PCD_OFF_CARD_DATA);
  wire              go_wr   = wr_take && (wa == `PCD_OFF_CARD_CMD) && s_axi_wstrb[1] &&
                              s_axi_wdata[`PCD_CMD_GO_BIT];

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PCD_RESP_OKAY;
      sel_reg      <= `PCD_SEL_NONE;
      hs_en_reg    <= 1'b0;
      dma_en_reg   <= 1'b0;
      cmd_kind_reg <= `PCD_KIND_MEM;
      cmd_wr_reg   <= 1'b0;
      cmd_wide_reg <= 1'b0;
      cmd_addr_reg <= {ADDR_W{1'b0}};
      cmd_data_reg <= {DATA_W{1'b0}};
      ord_pend_reg <= 1'b0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // The clear wins over a new command in the same cycle; that GO is ignored
      if (go_wr && !ord_pend_reg) begin
        ord_pend_reg <= 1'b1;
      end else if (start_reg && !own_dma_reg) begin
        ord_pend_reg <= 1'b0;
      end
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_map ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
        if (s_axi_wstrb[0]) begin
          if (wa == `PCD_OFF_EXT_CTRL1) begin
            sel_reg <= s_axi_wdata[`PCD_SEL_HI:`PCD_SEL_LO];
          end
          if (wa == `PCD_OFF_MISC_CTRL2) begin
            hs_en_reg  <= s_axi_wdata[`PCD_HS_EN_BIT];
            dma_en_reg <= s_axi_wdata[`PCD_DMA_EN_BIT];
          end
          // Command fields are frozen while a command waits
          if (wa == `PCD_OFF_CARD_CMD && !ord_pend_reg) begin
            cmd_kind_reg <= s_axi_wdata[`PCD_CMD_KIND_HI:`PCD_CMD_KIND_LO];
            cmd_wr_reg   <= s_axi_wdata[`PCD_CMD_WR_BIT];
            cmd_wide_reg <= s_axi_wdata[`PCD_CMD_WIDE_BIT];
          end
          if (wa == `PCD_OFF_CARD_ADDR && !ord_pend_reg) begin
            cmd_addr_reg[7:0] <= s_axi_wdata[7:0];
          end
          if (wa == `PCD_OFF_CARD_DATA && !ord_pend_reg) begin
            cmd_data_reg[7:0] <= s_axi_wdata[7:0];
          end
        end
        if (s_axi_wstrb[1] && !ord_pend_reg) begin
          if (wa == `PCD_OFF_CARD_ADDR) begin
            cmd_addr_reg[ADDR_W-1:8] <= s_axi_wdata[ADDR_W-1:8];
          end
          if (wa == `PCD_OFF_CARD_DATA) begin
            cmd_data_reg[DATA_W-1:8] <= s_axi_wdata[DATA_W-1:8];
          end
        end
      end
    end
  end

  // Ordinary read result kept for software
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= {DATA_W{1'b0}};
    end else if (gen_done && !own_dma_reg && !cmd_wr_reg) begin
      rd_data_reg <= gen_rdata;
    end
  end

  // AXI4-Lite read
  reg [31:0] rd_mux;
  reg        rd_err;

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `PCD_OFF_EXT_CTRL1: rd_mux[`PCD_SEL_HI:`PCD_SEL_LO] = sel_reg;
      `PCD_OFF_MISC_CTRL2: begin
        rd_mux[`PCD_HS_EN_BIT]  = hs_en_reg;
        rd_mux[`PCD_DMA_EN_BIT] = dma_en_reg;
      end
      `PCD_OFF_STATUS: begin
        rd_mux[`PCD_STS_DRQ_BIT]    = isa_irq10_out;
        rd_mux[`PCD_STS_DACK_BIT]   = dack_on;
        rd_mux[`PCD_STS_BUSY_BIT]   = gen_busy;
        rd_mux[`PCD_STS_PEND_BIT]   = ord_pend_reg;
        rd_mux[`PCD_STS_IOIS16_BIT] = (sel_reg == `PCD_SEL_IOIS16) & iois16_b_s;
      end
      `PCD_OFF_CARD_CMD: begin
        rd_mux[`PCD_CMD_KIND_HI:`PCD_CMD_KIND_LO] = cmd_kind_reg;
        rd_mux[`PCD_CMD_WR_BIT]   = cmd_wr_reg;
        rd_mux[`PCD_CMD_WIDE_BIT] = cmd_wide_reg;
        rd_mux[`PCD_CMD_GO_BIT]   = ord_pend_reg;
      end
      `PCD_OFF_CARD_ADDR: rd_mux[ADDR_W-1:0] = cmd_addr_reg;
      `PCD_OFF_CARD_DATA: rd_mux[DATA_W-1:0] = rd_data_reg;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PCD_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_err ? `PCD_RESP_SLVERR : `PCD_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: logic/pcd_defs.vh
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH

// Register byte offsets
`define PCD_OFF_EXT_CTRL1   8'h00
`define PCD_OFF_MISC_CTRL2  8'h04
`define PCD_OFF_STATUS      8'h08
`define PCD_OFF_CARD_CMD    8'h0C
`define PCD_OFF_CARD_ADDR   8'h10
`define PCD_OFF_CARD_DATA   8'h14

// Field positions
`define PCD_SEL_HI          7
`define PCD_SEL_LO          6
`define PCD_HS_EN_BIT       2
`define PCD_DMA_EN_BIT      6
`define PCD_STS_DRQ_BIT     0
`define PCD_STS_DACK_BIT    1
`define PCD_STS_BUSY_BIT    2
`define PCD_STS_PEND_BIT    3
`define PCD_STS_IOIS16_BIT  4
`define PCD_CMD_KIND_HI     1
`define PCD_CMD_KIND_LO     0
`define PCD_CMD_WR_BIT      2
`define PCD_CMD_WIDE_BIT    3
`define PCD_CMD_GO_BIT      8

// Request select codes
`define PCD_SEL_NONE        2'h0
`define PCD_SEL_INPACK      2'h1
`define PCD_SEL_IOIS16      2'h2
`define PCD_SEL_SPKR        2'h3

// Card cycle kinds
`define PCD_KIND_MEM        2'h0
`define PCD_KIND_ATTR       2'h1
`define PCD_KIND_IO         2'h2
`define PCD_KIND_DMA        2'h3

// AXI responses
`define PCD_RESP_OKAY       2'h0
`define PCD_RESP_SLVERR     2'h2

// Timing
`define PCD_CLK_NS          100
`define PCD_STROBE_NS       300

`endif

// file: logic/pcd_cycle_gen.v
`timescale 1ns/1ns
`include "pcd_defs.vh"

module pcd_cycle_gen #(
  parameter DATA_W = 16,
  parameter ADDR_W = 16
) (
  input  wire              sys_clk,
  input  wire              rst_b,
  input  wire              start,
  input  wire [1:0]        kind,
  input  wire              wr,
  input  wire              tc,
  input  wire              wide,
  input  wire [ADDR_W-1:0] addr,
  input  wire [DATA_W-1:0] wdata,
  input  wire [DATA_W-1:0] card_d_in,
  output wire              busy,
  output reg               done_reg,
  output reg  [DATA_W-1:0] rdata_reg,
  output reg               card_we_b_reg,
  output reg               card_oe_b_reg,
  output reg               card_iord_b_reg,
  output reg               card_iowr_b_reg,
  output reg               card_reg_b_reg,
  output reg  [1:0]        card_ce_b_reg,
  output reg  [ADDR_W-1:0] card_addr_reg,
  output reg  [DATA_W-1:0] card_d_out_reg,
  output reg               card_d_oe_reg
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SETUP  = 2'h1;
  localparam [1:0] ST_STROBE = 2'h2;
  localparam [1:0] ST_HOLD   = 2'h3;
  // Least strobe time rounds up to whole clocks
  localparam integer STB_CYC = (`PCD_STROBE_NS + `PCD_CLK_NS - 1) / `PCD_CLK_NS;
  localparam integer STB_LAST_I = STB_CYC - 1;
  localparam [3:0] STB_LAST = STB_LAST_I[3:0];

  reg [1:0] state_reg;
  reg [1:0] kind_reg;
  reg       wr_reg;
  reg       tc_reg;
  reg [3:0] cnt_reg;

  assign busy = (state_reg != ST_IDLE);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg       <= ST_IDLE;
      kind_reg        <= `PCD_KIND_MEM;
      wr_reg          <= 1'b0;
      tc_reg          <= 1'b0;
      cnt_reg         <= 4'h0;
      done_reg        <= 1'b0;
      rdata_reg       <= {DATA_W{1'b0}};
      card_we_b_reg   <= 1'b1;
      card_oe_b_reg   <= 1'b1;
      card_iord_b_reg <= 1'b1;
      card_iowr_b_reg <= 1'b1;
      card_reg_b_reg  <= 1'b1;
      card_ce_b_reg   <= 2'h3;
      card_addr_reg   <= {ADDR_W{1'b0}};
      card_d_out_reg  <= {DATA_W{1'b0}};
      card_d_oe_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            kind_reg       <= kind;
            wr_reg         <= wr;
            tc_reg         <= tc;
            // Address carries nothing meaningful on DMA cycles
            card_addr_reg  <= (kind == `PCD_KIND_DMA) ? {ADDR_W{1'b0}} : addr;
            card_reg_b_reg <= (kind == `PCD_KIND_MEM) || (kind == `PCD_KIND_DMA);
            card_ce_b_reg  <= {~wide, 1'b0};
            card_d_out_reg <= wdata;
            card_d_oe_reg  <= wr;
            state_reg      <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          case (kind_reg)
            `PCD_KIND_MEM, `PCD_KIND_ATTR: begin
              card_we_b_reg <= ~wr_reg;
              card_oe_b_reg <= wr_reg;
            end
            `PCD_KIND_IO: begin
              card_iowr_b_reg <= ~wr_reg;
              card_iord_b_reg <= wr_reg;
            end
            default: begin
              card_iowr_b_reg <= ~wr_reg;
              card_iord_b_reg <= wr_reg;
              card_we_b_reg   <= ~(wr_reg & tc_reg);
              card_oe_b_reg   <= ~(~wr_reg & tc_reg);
            end
          endcase
          cnt_reg   <= STB_LAST;
          state_reg <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_reg == 4'h0) begin
            rdata_reg       <= card_d_in;
            card_we_b_reg   <= 1'b1;
            card_oe_b_reg   <= 1'b1;
            card_iord_b_reg <= 1'b1;
            card_iowr_b_reg <= 1'b1;
            state_reg       <= ST_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_HOLD: begin
          // Acknowledge level lasts only for the cycle itself
          card_reg_b_reg <= 1'b1;
          card_ce_b_reg  <= 2'h3;
          card_d_oe_reg  <= 1'b0;
          done_reg       <= 1'b1;
          state_reg      <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: test/pcd_dma_props.sv
`timescale 1ns/1ns
module pcd_dma_props #(
  parameter DATA_W = 16,
  parameter ADDR_W = 16
) (
  input wire              sys_clk,
  input wire              rst_b,
  input wire              fifo_empty,
  input wire              isa_irq9_in,
  input wire              isa_ior_b,
  input wire              isa_rdy,
  input wire              isa_irq10_out,
  input wire [ADDR_W-1:0] card_addr,
  input wire              card_we_b,
  input wire              card_oe_b,
  input wire              card_iord_b,
  input wire              card_iowr_b,
  input wire              card_reg_b
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_io;
    (!card_iord_b || !card_iowr_b) && !card_reg_b |-> card_we_b && card_oe_b;
  endproperty
  a_io: assert property (p_io) else $error("I/O cycle moved WE or OE");
  property p_mem;
    !card_oe_b && card_iord_b |-> card_iowr_b;
  endproperty
  a_mem: assert property (p_mem) else $error("memory read with IOWR low");
  property p_len;
    $fell(card_iord_b) |-> !card_iord_b [*3] ##1 card_iord_b;
  endproperty
  a_len: assert property (p_len) else $error("read strobe not three cycles");
  property p_tc_oe;
    !card_oe_b && !card_iord_b |-> card_reg_b && card_iowr_b;
  endproperty
  a_tc_oe: assert property (p_tc_oe) else $error("OE count outside DMA read");
  property p_tc_we;
    !card_we_b && !card_iowr_b |-> card_reg_b && card_iord_b;
  endproperty
  a_tc_we: assert property (p_tc_we) else $error("WE count outside DMA write");
  property p_drq;
    isa_irq10_out |-> fifo_empty;
  endproperty
  a_drq: assert property (p_drq) else $error("request with FIFO not empty");
  property p_addr;
    card_reg_b && (!card_iord_b || !card_iowr_b) |-> card_addr == {ADDR_W{1'b0}};
  endproperty
  a_addr: assert property (p_addr) else $error("address moved in DMA cycle");
  // Synchronisers add latency, so the cause is looked for four edges back
  property p_start;
    $fell(card_iord_b) && card_reg_b |->
      !isa_rdy && !$past(isa_ior_b, 4) && !$past(isa_irq9_in, 4);
  endproperty
  a_start: assert property (p_start) else $error("DMA read without cause");
  c_dma_rd: cover property (!card_iord_b && card_reg_b);
  c_dma_wr: cover property (!card_iowr_b && card_reg_b);
  c_io: cover property (!card_iord_b && !card_reg_b);
endmodule
bind pcd_dma pcd_dma_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .fifo_empty(fifo_empty), .isa_irq9_in(isa_irq9_in),
  .isa_ior_b(isa_ior_b), .isa_rdy(isa_rdy), .isa_irq10_out(isa_irq10_out),
  .card_addr(card_addr), .card_we_b(card_we_b), .card_oe_b(card_oe_b),
  .card_iord_b(card_iord_b), .card_iowr_b(card_iowr_b), .card_reg_b(card_reg_b));

// file: test/pcd_card_model.sv
`timescale 1ns/1ns
module pcd_card_model #(
  parameter [15:0] RD_DATA = 16'h0000
) (
  input  wire        sys_clk,
  input  wire        card_we_b,
  input  wire        card_oe_b,
  input  wire        card_iord_b,
  input  wire        card_iowr_b,
  input  wire [15:0] card_d_out,
  output wire [15:0] card_d_in,
  output reg  [15:0] wr_data_reg
);
  reg [15:0] last_reg = 16'h0000;
  // Bus toggles when no read strobe is low, so a late sample cannot pass
  assign card_d_in = (!card_iord_b || !card_oe_b) ? RD_DATA : ~last_reg;
  // Address lines are never looked at
  always @(posedge sys_clk) begin
    last_reg <= card_d_in;
    if (!card_iowr_b || !card_we_b)
      wr_data_reg <= card_d_out;
  end
endmodule

// file: test/tb_pcd_dma.sv
`timescale 1ns/1ns
module tb_pcd_dma;
  localparam [15:0] WORD = 16'hA5C3;
  reg         sys_clk = 1'h0, rst_b = 1'h0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0, rd;
  reg         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg         fifo_empty = 1'h1, irq9 = 1'h1, ior_b = 1'h1, iow_b = 1'h1;
  reg         tc = 1'h0, dma16 = 1'h0, tc_lo = 1'h0;
  reg         inpack_b = 1'h1, iois16_b = 1'h1, spkr_b = 1'h1;
  reg  [15:0] isa_d = 16'h0;
  reg  [2:0]  ce_seen = 3'h0;
  reg  [6:0]  rows [0:5];
  reg  [18:0] drows [0:2];
  wire        awready, bvalid, arready, rvalid, isa_rdy, irq10, irq10_oe, spkr_out;
  wire        we_b, oe_b, iord_b, iowr_b, reg_b, wready, d_oe, cd_oe;
  wire [1:0]  bresp, rresp, ce_b;
  wire [31:0] rdata;
  wire [15:0] isa_q, card_din, card_dout, wr_data;
  integer     n_errors = 0, num_checks = 0, cyc = 0, i;
  pcd_dma uut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fifo_empty(fifo_empty), .isa_irq9_in(irq9), .isa_ior_b(ior_b), .isa_iow_b(iow_b),
    .isa_tc_in(tc), .isa_dma16(dma16), .isa_d_in(isa_d), .isa_d_out_reg(isa_q),
    .isa_d_oe(d_oe), .isa_rdy(isa_rdy), .isa_irq10_out(irq10), .isa_irq10_oe(irq10_oe),
    .card_inpack_b(inpack_b), .card_iois16_b(iois16_b), .card_spkr_b(spkr_b),
    .spkr_out(spkr_out), .card_d_in(card_din), .card_d_out(card_dout), .card_d_oe(cd_oe),
    .card_addr(), .card_ce_b(ce_b), .card_we_b(we_b), .card_oe_b(oe_b),
    .card_iord_b(iord_b), .card_iowr_b(iowr_b), .card_reg_b(reg_b));
  pcd_card_model #(.RD_DATA(WORD)) u_card (.sys_clk(sys_clk), .card_we_b(we_b),
    .card_oe_b(oe_b), .card_iord_b(iord_b), .card_iowr_b(iowr_b), .card_d_out(card_dout),
    .card_d_in(card_din), .wr_data_reg(wr_data));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task done(input [63:0] nm);
    $display("test %0s done", nm);
  endtask
  task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge sys_clk); while (awready !== 1'h1);
      chk(wready, 32'h1);
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      do @(posedge sys_clk); while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(bresp, er);
    end
  endtask
  task axi_rd(input [7:0] a, input [1:0] er);
    begin
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge sys_clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge sys_clk); while (rvalid !== 1'h1);
      rd = rdata;
      rready <= 1'h0;
      chk(rresp, er);
    end
  endtask
  // Strobe is held until ready returns; gap lets the synchroniser see it high
  task dma(input rd_op, input t, input w, input [15:0] d);
    begin
      repeat (3) @(posedge sys_clk);
      tc <= t;
      dma16 <= w;
      isa_d <= d;
      if (rd_op) ior_b <= 1'h0;
      else iow_b <= 1'h0;
      do @(posedge sys_clk); while (isa_rdy !== 1'h0);
      do @(posedge sys_clk); while (isa_rdy !== 1'h1);
      chk(d_oe, rd_op);
      ior_b <= 1'h1;
      iow_b <= 1'h1;
      tc <= 1'h0;
      @(negedge sys_clk);
    end
  endtask
  always @(posedge sys_clk)
    if ((!iord_b || !iowr_b) && reg_b) begin
      tc_lo <= tc_lo | ~(oe_b & we_b);
      ce_seen <= {cd_oe, ce_b};
    end else if (ior_b && iow_b) begin
      tc_lo <= 1'h0;
    end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  initial begin
    rows[0] = 7'h2F;
    rows[1] = 7'h2C;
    rows[2] = 7'h57;
    rows[3] = 7'h4A;
    rows[4] = 7'h7B;
    rows[5] = 7'h02;
    drows[0] = 19'h70000;
    drows[1] = 19'h0005A;
    drows[2] = 19'h33C96;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(negedge sys_clk);
    chk({isa_rdy, irq10_oe, reg_b, oe_b, we_b, iord_b, iowr_b, ce_b}, 32'h17F);
    done("reset");
    axi_wr(8'h04, 32'h44, 2'h0);
    chk(irq10_oe, 32'h1);
    for (i = 0; i < 6; i = i + 1) begin
      axi_wr(8'h00, {24'h0, rows[i][6:5], 6'h00}, 2'h0);
      {inpack_b, iois16_b, spkr_b, fifo_empty} <= rows[i][4:1];
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(irq10, rows[i][0]);
      chk(spkr_out, (rows[i][6:5] == 2'h3) ? 1'h0 : !rows[i][2]);
      axi_rd(8'h08, 2'h0);
      chk(rd[4], (rows[i][6:5] == 2'h2) ? rows[i][3] : 1'h0);
    end
    done("select");
    axi_wr(8'h00, 32'h40, 2'h0);
    irq9 <= 1'h0;
    for (i = 0; i < 3; i = i + 1) begin
      dma(drows[i][18], drows[i][17], drows[i][16], drows[i][15:0]);
      if (drows[i][18])
        chk(isa_q, WORD);
      else
        chk(wr_data & (drows[i][16] ? 16'hFFFF : 16'h00FF), drows[i][15:0]);
      chk(tc_lo, drows[i][17]);
      chk(ce_seen, {!drows[i][18], !drows[i][16], 1'h0});
    end
    done("dma");
    for (i = 0; i < 2; i = i + 1) begin
      axi_wr(8'h0C, 32'h100 + i * 2, 2'h0);
      dma(1'h1, 1'h0, 1'h1, 16'h0000);
      chk(isa_q, WORD);
      do axi_rd(8'h08, 2'h0); while (rd[3:2] !== 2'h0);
      axi_rd(8'h14, 2'h0);
      chk(rd, {16'h0, WORD});
    end
    // A DMA-kind command with no request select must stay a plain cycle
    axi_wr(8'h00, 32'h0, 2'h0);
    axi_wr(8'h0C, 32'h103, 2'h0);
    do axi_rd(8'h08, 2'h0); while (rd[3:2] !== 2'h0);
    chk(ce_seen, 32'h0);
    done("mixed");
    axi_rd(8'h1C, 2'h2);
    chk(rd, 32'h0);
    axi_wr(8'h20, 32'h1, 2'h2);
    done("unmapped");
    wrap_up;
  end
endmodule
